// >>> src/cpe_defines.vh
// Constants for the counter channel: register map, fields, reset values.
// Assumes a 32-bit classic Wishbone bus with byte addressing.
`ifndef CPE_DEFINES_VH
`define CPE_DEFINES_VH

// ****************************************
// Register byte offsets
// ****************************************
`define CPE_ADR_CTRL    8'h00
`define CPE_ADR_STATUS  8'h04
`define CPE_ADR_INIT    8'h08
`define CPE_ADR_DELAY   8'h0c
`define CPE_ADR_WIDTH   8'h10
`define CPE_ADR_COUNT   8'h14
`define CPE_ADR_FIFO    8'h18

// ****************************************
// Control fields
// ****************************************
`define CPE_CTRL_ARM     0
`define CPE_CTRL_DISARM  1
`define CPE_CTRL_MODE_LO 4
`define CPE_CTRL_MODE_HI 6
`define CPE_CTRL_DEC_LO  8
`define CPE_CTRL_DEC_HI  9
`define CPE_CTRL_SRC_F   12
`define CPE_CTRL_GATE_F  13
`define CPE_CTRL_AUX_F   14
`define CPE_CTRL_SMP_F   15
`define CPE_CTRL_SMP_G   16
`define CPE_CTRL_RST     32'h0000_0000

// ****************************************
// Status fields
// ****************************************
`define CPE_ST_ARMED     0
`define CPE_ST_DONE      1
`define CPE_ST_OVERRUN   2
`define CPE_ST_FIFO_OVF  3
`define CPE_ST_EMPTY     4
`define CPE_ST_FULL      5
`define CPE_ST_PULSE     6

// ****************************************
// Mode and decode codes
// ****************************************
`define CPE_MODE_POS      3'h0
`define CPE_MODE_POS_HWT  3'h1
`define CPE_MODE_SEP_ONE  3'h2
`define CPE_MODE_SEP_IMP  3'h3
`define CPE_MODE_SEP_SMP  3'h4
`define CPE_MODE_SEP_HWT  3'h5
`define CPE_MODE_PULSE    3'h6
`define CPE_MODE_PULSE_TR 3'h7

`define CPE_DEC_SINGLE    2'h0
`define CPE_DEC_DOUBLE    2'h1
`define CPE_DEC_QUAD      2'h2
`define CPE_DEC_TWO_PULSE 2'h3

// ****************************************
// Reset values
// ****************************************
`define CPE_INIT_RST      32'h0000_0000
`define CPE_DELAY_RST     32'h0000_0000
`define CPE_WIDTH_RST     32'h0000_0001

`endif

// >>> src/cpe_sync_edge.v
// Three-stage synchroniser with edge detection for a group of pins.
// Assumes inputs are asynchronous to clk_i.
`timescale 1ns/1ns
module cpe_sync_edge #(
	parameter W = 6
) (
	// Clock and reset
	input  wire         clk_i,
	input  wire         rst_i,
	// Pins and detected levels and edges
	input  wire [W-1:0] pin_i,
	output reg  [W-1:0] lvl_o,
	output reg  [W-1:0] rise_o,
	output reg  [W-1:0] fall_o
);

	reg [W-1:0] s1_q;
	reg [W-1:0] s2_q;
	reg [W-1:0] s3_q;
	wire [W-1:0] agree;
	wire [W-1:0] lvl_d;

	// A change counts only once stages two and three agree
	assign agree = ~(s2_q ^ s3_q);
	assign lvl_d = (agree & s2_q) | (~agree & lvl_o);

	always @(posedge clk_i) begin
		if (rst_i) begin
			s1_q   <= {W{1'b0}};
			s2_q   <= {W{1'b0}};
			s3_q   <= {W{1'b0}};
			lvl_o  <= {W{1'b0}};
			rise_o <= {W{1'b0}};
			fall_o <= {W{1'b0}};
		end else begin
			s1_q   <= pin_i;
			s2_q   <= s1_q;
			s3_q   <= s2_q;
			lvl_o  <= lvl_d;
			rise_o <= lvl_d & ~lvl_o;
			fall_o <= ~lvl_d & lvl_o;
		end
	end

endmodule

// >>> src/cpe_counter.v
// Counter channel: position capture, edge separation, single pulse.
// Assumes a classic Wishbone master and a DMA engine on the result stream.
`timescale 1ns/1ns
`include "cpe_defines.vh"
module cpe_counter #(
	parameter CW    = 32,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	// Clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// Wishbone slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	// Counter pins
	input  wire        enc_a_i,
	input  wire        enc_b_i,
	input  wire        source_i,
	input  wire        gate_i,
	input  wire        second_edge_i,
	input  wire        sample_clk_i,
	output reg         pulse_o,
	// Result stream to DMA
	output reg         dma_valid_o,
	output reg  [31:0] dma_data_o,
	input  wire        dma_ready_i
);

	// ****************************************
	// States
	// ****************************************
	localparam [3:0] ST_IDLE    = 4'h0;
	localparam [3:0] ST_POS     = 4'h1;
	localparam [3:0] ST_WAIT2   = 4'h2;
	localparam [3:0] ST_RUN     = 4'h3;
	localparam [3:0] ST_RESTART = 4'h4;
	localparam [3:0] ST_DONE    = 4'h5;
	localparam [3:0] ST_DELAY   = 4'h6;
	localparam [3:0] ST_HIGH    = 4'h7;
	localparam [3:0] ST_TRIG    = 4'h8;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	wire [5:0] lvl;
	wire [5:0] rise;
	wire [5:0] fall;

	cpe_sync_edge #(
		.W(6)
	) u_sync (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.pin_i  ({sample_clk_i, second_edge_i, gate_i, source_i,
		          enc_b_i, enc_a_i}),
		.lvl_o  (lvl),
		.rise_o (rise),
		.fall_o (fall)
	);

	// ****************************************
	// Registers
	// ****************************************
	reg [31:0]   ctrl_q;
	reg [31:0]   init_q;
	reg [31:0]   delay_q;
	reg [31:0]   width_q;
	reg          arm_q;
	reg          disarm_q;
	reg          overrun_q;
	reg          fovf_q;
	reg [3:0]    st_q;
	reg [CW-1:0] cnt_q;
	reg [CW-1:0] res_q;
	reg          res_ok_q;
	reg          seen_gate_q;
	reg          seen_aux_q;
	reg [31:0]   mem [0:DEPTH-1];
	reg [AW-1:0] wp_q;
	reg [AW-1:0] rp_q;
	reg [AW:0]   fcnt_q;

	wire [2:0] mode = ctrl_q[`CPE_CTRL_MODE_HI:`CPE_CTRL_MODE_LO];
	wire [1:0] dec  = ctrl_q[`CPE_CTRL_DEC_HI:`CPE_CTRL_DEC_LO];

	// Selected active edges
	wire src_act  = ctrl_q[`CPE_CTRL_SRC_F] ? fall[2] : rise[2];
	wire gate_act = ctrl_q[`CPE_CTRL_GATE_F] ? fall[3] : rise[3];
	wire aux_act  = ctrl_q[`CPE_CTRL_AUX_F] ? fall[4] : rise[4];
	wire smp_r    = ctrl_q[`CPE_CTRL_SMP_G] ? rise[3] : rise[5];
	wire smp_f    = ctrl_q[`CPE_CTRL_SMP_G] ? fall[3] : fall[5];
	wire smp_act  = ctrl_q[`CPE_CTRL_SMP_F] ? smp_f : smp_r;

	wire sep_smp = (mode == `CPE_MODE_SEP_SMP) ||
	               (mode == `CPE_MODE_SEP_HWT);

	// ****************************************
	// Quadrature and two-pulse decode
	// ****************************************
	reg up;
	reg dn;
	always @* begin
		up = 1'b0;
		dn = 1'b0;
		case (dec)
		`CPE_DEC_SINGLE: begin
			up = rise[0] & ~lvl[1];
			dn = fall[0] & ~lvl[1];
		end
		`CPE_DEC_DOUBLE: begin
			up = (rise[0] & ~lvl[1]) | (fall[0] & lvl[1]);
			dn = (rise[0] & lvl[1]) | (fall[0] & ~lvl[1]);
		end
		`CPE_DEC_QUAD: begin
			up = (rise[0] & ~lvl[1]) | (fall[0] & lvl[1]) |
			     (rise[1] & lvl[0]) | (fall[1] & ~lvl[0]);
			dn = (rise[0] & lvl[1]) | (fall[0] & ~lvl[1]) |
			     (rise[1] & ~lvl[0]) | (fall[1] & lvl[0]);
		end
		default: begin
			up = rise[0];
			dn = rise[1];
		end
		endcase
	end

	// ****************************************
	// Bus decode
	// ****************************************
	wire acc    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wr     = acc & wb_we_i;
	wire rd     = acc & ~wb_we_i;
	wire sw_pop = rd & (wb_adr_i == `CPE_ADR_FIFO);

	function [31:0] merge;
		input [31:0] old;
		input [31:0] dat;
		input [3:0]  sel;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (sel[i]) begin
					merge[i*8 +: 8] = dat[i*8 +: 8];
				end
			end
		end
	endfunction

	// ****************************************
	// Measurement engine
	// ****************************************
	reg          push;
	reg [31:0]   push_dat;
	reg [3:0]    st_d;
	reg [CW-1:0] cnt_d;
	reg          pulse_d;
	reg          res_ok_d;
	reg          ovr_set;
	wire [CW-1:0] init_c = init_q[CW-1:0];

	always @* begin
		st_d     = st_q;
		cnt_d    = cnt_q;
		pulse_d  = pulse_o;
		res_ok_d = res_ok_q;
		push     = 1'b0;
		push_dat = 32'h0000_0000;
		ovr_set  = 1'b0;
		case (st_q)
		ST_IDLE: begin
			pulse_d = 1'b0;
		end
		ST_POS: begin
			if (up && !dn) begin
				cnt_d = cnt_q + 1'b1;
			end else if (dn && !up) begin
				cnt_d = cnt_q - 1'b1;
			end
			if (smp_act) begin
				push     = 1'b1;
				push_dat = cnt_d;
			end
		end
		ST_WAIT2: begin
			if (aux_act) begin
				st_d = ST_RUN;
			end
		end
		ST_RUN: begin
			if (src_act) begin
				cnt_d = cnt_q + 1'b1;
			end
			if (gate_act) begin
				cnt_d = cnt_q;
				if (sep_smp) begin
					res_ok_d = 1'b1;
				end else begin
					push     = 1'b1;
					push_dat = cnt_q;
				end
				if (mode == `CPE_MODE_SEP_ONE) begin
					st_d = ST_DONE;
				end else begin
					st_d = ST_RESTART;
				end
			end
		end
		ST_RESTART: begin
			if (gate_act) begin
				cnt_d = init_c;
				st_d  = ST_WAIT2;
			end
		end
		ST_DELAY: begin
			if (cnt_q >= delay_q[CW-1:0]) begin
				pulse_d = 1'b1;
				cnt_d   = {CW{1'b0}};
				st_d    = ST_HIGH;
			end else if (src_act) begin
				cnt_d = cnt_q + 1'b1;
			end
		end
		ST_HIGH: begin
			if (src_act) begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_d >= width_q[CW-1:0]) begin
					pulse_d = 1'b0;
					st_d    = ST_DONE;
				end
			end
		end
		ST_TRIG: begin
			if (gate_act) begin
				cnt_d = {CW{1'b0}};
				st_d  = ST_DELAY;
			end
		end
		default: begin
			pulse_d = 1'b0;
		end
		endcase
		// Sample edge in the sampled separation modes (CPE_MODE_SEP_SMP, CPE_MODE_SEP_HWT); results wait for it
		if (sep_smp && st_q != ST_IDLE && smp_act) begin
			if (!((seen_gate_q || gate_act) &&
			      (seen_aux_q || aux_act))) begin
				ovr_set = 1'b1;
			end
			if (res_ok_d) begin
				push     = 1'b1;
				push_dat = (res_ok_q) ? res_q : cnt_q;
				res_ok_d = 1'b0;
			end
		end
		if (arm_q) begin
			cnt_d    = init_c;
			pulse_d  = 1'b0;
			res_ok_d = 1'b0;
			case (mode)
			`CPE_MODE_POS,
			`CPE_MODE_POS_HWT:  st_d = ST_POS;
			`CPE_MODE_PULSE:    st_d = ST_DELAY;
			`CPE_MODE_PULSE_TR: st_d = ST_TRIG;
			default:            st_d = ST_WAIT2;
			endcase
			if (mode == `CPE_MODE_PULSE ||
			    mode == `CPE_MODE_PULSE_TR) begin
				cnt_d = {CW{1'b0}};
			end
		end
		if (disarm_q) begin
			st_d    = ST_IDLE;
			pulse_d = 1'b0;
		end
	end

	// ****************************************
	// Result FIFO and DMA output stage
	// ****************************************
	wire fifo_full = (fcnt_q == DEPTH[AW:0]);
	wire ostage_go = (fcnt_q != {(AW+1){1'b0}}) &&
	                 (!dma_valid_o || (dma_valid_o && dma_ready_i) ||
	                  sw_pop);
	wire do_push   = push && !fifo_full;
	wire do_pull   = ostage_go;

	always @(posedge clk_i) begin
		if (rst_i) begin
			wp_q        <= {AW{1'b0}};
			rp_q        <= {AW{1'b0}};
			fcnt_q      <= {(AW+1){1'b0}};
			dma_valid_o <= 1'b0;
			dma_data_o  <= 32'h0000_0000;
		end else begin
			if (do_push) begin
				mem[wp_q] <= push_dat;
				wp_q      <= wp_q + 1'b1;
			end
			if (do_pull) begin
				rp_q        <= rp_q + 1'b1;
				dma_data_o  <= mem[rp_q];
				dma_valid_o <= 1'b1;
			end else if ((dma_valid_o && dma_ready_i) || sw_pop) begin
				dma_valid_o <= 1'b0;
			end
			if (do_push && !do_pull) begin
				fcnt_q <= fcnt_q + 1'b1;
			end else if (!do_push && do_pull) begin
				fcnt_q <= fcnt_q - 1'b1;
			end
		end
	end

	// ****************************************
	// Engine registers and bus slave
	// ****************************************
	always @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q      <= `CPE_CTRL_RST;
			init_q      <= `CPE_INIT_RST;
			delay_q     <= `CPE_DELAY_RST;
			width_q     <= `CPE_WIDTH_RST;
			arm_q       <= 1'b0;
			disarm_q    <= 1'b0;
			overrun_q   <= 1'b0;
			fovf_q      <= 1'b0;
			st_q        <= ST_IDLE;
			cnt_q       <= {CW{1'b0}};
			res_q       <= {CW{1'b0}};
			res_ok_q    <= 1'b0;
			seen_gate_q <= 1'b0;
			seen_aux_q  <= 1'b0;
			pulse_o     <= 1'b0;
			wb_ack_o    <= 1'b0;
			wb_dat_o    <= 32'h0000_0000;
		end else begin
			st_q     <= st_d;
			cnt_q    <= cnt_d;
			pulse_o  <= pulse_d;
			res_ok_q <= res_ok_d;
			if (st_q == ST_RUN && gate_act) begin
				res_q <= cnt_q;
			end
			// Seen flags span one sample period
			if ((sep_smp && smp_act) || arm_q) begin
				seen_gate_q <= 1'b0;
				seen_aux_q  <= 1'b0;
			end else begin
				seen_gate_q <= seen_gate_q | gate_act;
				seen_aux_q  <= seen_aux_q | aux_act;
			end
			arm_q    <= wr && wb_adr_i == `CPE_ADR_CTRL &&
			            wb_sel_i[0] && wb_dat_i[`CPE_CTRL_ARM];
			disarm_q <= wr && wb_adr_i == `CPE_ADR_CTRL &&
			            wb_sel_i[0] && wb_dat_i[`CPE_CTRL_DISARM];
			// Set wins over a clear in the same cycle
			if (ovr_set) begin
				overrun_q <= 1'b1;
			end else if (wr && wb_adr_i == `CPE_ADR_STATUS &&
			             wb_sel_i[0] && wb_dat_i[`CPE_ST_OVERRUN]) begin
				overrun_q <= 1'b0;
			end
			if (push && fifo_full) begin
				fovf_q <= 1'b1;
			end else if (wr && wb_adr_i == `CPE_ADR_STATUS &&
			             wb_sel_i[0] && wb_dat_i[`CPE_ST_FIFO_OVF]) begin
				fovf_q <= 1'b0;
			end
			if (wr) begin
				case (wb_adr_i)
				`CPE_ADR_CTRL: begin
					ctrl_q <= merge(ctrl_q, wb_dat_i, wb_sel_i) &
					          32'hffff_fffc;
				end
				`CPE_ADR_INIT:  init_q <= merge(init_q, wb_dat_i, wb_sel_i);
				`CPE_ADR_DELAY: delay_q <= merge(delay_q, wb_dat_i, wb_sel_i);
				`CPE_ADR_WIDTH: width_q <= merge(width_q, wb_dat_i, wb_sel_i);
				default: begin
				end
				endcase
			end
			wb_ack_o <= acc;
			if (rd) begin
				case (wb_adr_i)
				`CPE_ADR_CTRL:   wb_dat_o <= ctrl_q;
				`CPE_ADR_STATUS: wb_dat_o <= {16'h0000,
					{(7-AW){1'b0}}, fcnt_q, 1'b0, pulse_o, fifo_full,
					~dma_valid_o, fovf_q, overrun_q,
					st_q == ST_DONE, st_q != ST_IDLE};
				`CPE_ADR_INIT:   wb_dat_o <= init_q;
				`CPE_ADR_DELAY:  wb_dat_o <= delay_q;
				`CPE_ADR_WIDTH:  wb_dat_o <= width_q;
				`CPE_ADR_COUNT:  wb_dat_o <= cnt_q;
				`CPE_ADR_FIFO:   wb_dat_o <= dma_valid_o ? dma_data_o :
				                             32'h0000_0000;
				default:         wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

endmodule

// >>> bench/cpe_counter_props.sv
// Port checker for the counter channel.
// Assumes it is bound to cpe_counter and sees only its ports.
`timescale 1ns/1ns
module cpe_counter_props (
	// Clock and reset
	input wire        clk_i,
	input wire        rst_i,
	// Bus and pins
	input wire        wb_cyc_i,
	input wire        wb_stb_i,
	input wire        wb_we_i,
	input wire [7:0]  wb_adr_i,
	input wire [31:0] wb_dat_o,
	input wire        wb_ack_o,
	input wire        source_i,
	input wire        gate_i,
	input wire        sample_clk_i,
	input wire        pulse_o,
	input wire        dma_valid_o,
	input wire [31:0] dma_data_o,
	input wire        dma_ready_i
);
	// ****************************************
	// Event ages and properties
	// ****************************************
	logic [7:0] src_age_q;
	logic [7:0] evt_age_q;
	wire        req = wb_cyc_i && wb_stb_i;
	default clocking cb @(posedge clk_i); endclocking
	// Ages saturate so a long idle never wraps into a false match
	always @(posedge clk_i) begin
		if (rst_i || $changed(source_i) || (wb_ack_o && wb_we_i))
			src_age_q <= 8'h00;
		else
			src_age_q <= src_age_q + {7'h00, src_age_q != 8'hff};
		if (rst_i || $changed(gate_i) || $changed(sample_clk_i) ||
		    (dma_valid_o && dma_ready_i) || (wb_ack_o && !wb_we_i))
			evt_age_q <= 8'h00;
		else
			evt_age_q <= evt_age_q + {7'h00, evt_age_q != 8'hff};
	end
	property p_ack_taken;
		disable iff (rst_i) req && !wb_ack_o |=> wb_ack_o;
	endproperty
	property p_ack_one;
		disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
	endproperty
	property p_ack_cause;
		disable iff (rst_i) !req |=> !wb_ack_o;
	endproperty
	property p_unmapped;
		disable iff (rst_i) req && !wb_we_i && !wb_ack_o &&
			wb_adr_i == 8'h1c |=> wb_dat_o == 32'h0;
	endproperty
	property p_reset;
		rst_i |=> !wb_ack_o && !dma_valid_o && !pulse_o;
	endproperty
	property p_dma_hold;
		disable iff (rst_i) dma_valid_o && !dma_ready_i && !req
			|=> dma_valid_o && $stable(dma_data_o);
	endproperty
	property p_dma_cause;
		disable iff (rst_i) $rose(dma_valid_o) |-> evt_age_q <= 8'd10;
	endproperty
	property p_pulse_cause;
		disable iff (rst_i) $changed(pulse_o) |-> src_age_q <= 8'd8;
	endproperty
	a_ack_taken: assert property (p_ack_taken)
		else $error("ack missing after request");
	a_ack_one: assert property (p_ack_one)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property (p_ack_cause)
		else $error("ack without request");
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	a_reset: assert property (p_reset)
		else $error("outputs active after reset");
	a_dma_hold: assert property (p_dma_hold)
		else $error("stream word dropped or changed");
	a_dma_cause: assert property (p_dma_cause)
		else $error("stream word without capture event");
	a_pulse_cause: assert property (p_pulse_cause)
		else $error("pulse change without source edge");
	c_pulse: cover property ($rose(pulse_o));
	c_dma: cover property (dma_valid_o && dma_ready_i);
	c_wr: cover property (wb_ack_o && wb_we_i);
endmodule

// >>> bench/cpe_pins_model.sv
// Far-side pins: encoder A and B, timebase, gate, start, sample clock.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/1ns
module cpe_pins_model (
	// Clock
	input  wire  clk_i,
	// Pins
	output logic enc_a_o,
	output logic enc_b_o,
	output logic src_o,
	output logic gate_o,
	output logic sec_o,
	output logic smp_o
);
	// ****************************************
	// Pin drive
	// ****************************************
	logic [5:0] pin_q = 6'h00;
	int         hold = 6;
	assign {smp_o, sec_o, gate_o, src_o, enc_b_o, enc_a_o} = pin_q;
	// Levels stand at least two cycles or the synchroniser misses them
	task automatic tog(input int p);
		@(posedge clk_i);
		pin_q[p] <= ~pin_q[p];
		repeat (hold) @(posedge clk_i);
	endtask
	task automatic pls(input int p);
		tog(p);
		tog(p);
	endtask
	// Forward steps A before B, reverse B before A
	task automatic quad(input bit fwd);
		for (int i = 0; i < 4; i++)
			tog(fwd ? i % 2 : 1 - i % 2);
	endtask
endmodule

// >>> bench/test_cpe_counter.sv
// Self-checking bench for the counter channel.
// Assumes the pin model and the port checker beside the design.
`timescale 1ns/1ns
`include "cpe_defines.vh"
module test_cpe_counter;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic        rdy = 1'b0;
	logic [3:0]  sel = 4'hf;
	logic [3:0]  msk = 4'hf;
	logic [31:0] q;
	logic [31:0] dq[$];
	int          err_count = 0;
	int          checked = 0;
	wire  [31:0] rdat, ddat;
	wire         ack, dval, pulse, ea, eb, src, gate, sec, smp;
	always #5 clk_i = ~clk_i;
	cpe_pins_model m (.clk_i(clk_i), .enc_a_o(ea), .enc_b_o(eb),
		.src_o(src), .gate_o(gate), .sec_o(sec), .smp_o(smp));
	cpe_counter #(.CW(32), .DEPTH(16), .AW(4)) uut (.clk_i(clk_i),
		.rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .enc_a_i(ea), .enc_b_i(eb),
		.source_i(src), .gate_i(gate), .second_edge_i(sec),
		.sample_clk_i(smp), .pulse_o(pulse), .dma_valid_o(dval),
		.dma_data_o(ddat), .dma_ready_i(rdy));
	always @(posedge clk_i)
		if (dval === 1'b1 && rdy === 1'b1)
			dq.push_back(ddat);
	// ****************************************
	// Tasks
	// ****************************************
	task automatic end_of_test();
		$display("Checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wb(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		{cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, msk};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1) begin
			err_count++;
			end_of_test();
		end
		q = rdat;
		{cyc, stb} <= 2'b00;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e,
		input string n);
		wb(a, 1'b0, 32'h0);
		chk(n, e, q);
	endtask
	task automatic ovr(input logic e);
		wb(`CPE_ADR_STATUS, 1'b0, 32'h0);
		chk("overrun", {31'h0, e}, {31'h0, q[`CPE_ST_OVERRUN]});
	endtask
	task automatic sep(input int n);
		m.pls(4);
		repeat (n) m.pls(2);
		m.pls(3);
	endtask
	initial begin
		repeat (100000) @(posedge clk_i);
		err_count++;
		end_of_test();
	end
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		rc(`CPE_ADR_CTRL, `CPE_CTRL_RST, "ctrl");
		rc(`CPE_ADR_INIT, `CPE_INIT_RST, "init");
		rc(`CPE_ADR_DELAY, `CPE_DELAY_RST, "delay");
		rc(`CPE_ADR_WIDTH, `CPE_WIDTH_RST, "width");
		rc(`CPE_ADR_STATUS, 32'h10, "status");
		wb(`CPE_ADR_COUNT, 1'b1, 32'h5);
		rc(`CPE_ADR_COUNT, 32'h0, "count_ro");
		rc(8'h1c, 32'h0, "unmapped");
		msk = 4'h1;
		wb(`CPE_ADR_INIT, 1'b1, 32'hffff_ffff);
		msk = 4'hf;
		rc(`CPE_ADR_INIT, 32'h0000_00ff, "init_byte");
		for (int md = 0; md < 2; md++) begin
			wb(`CPE_ADR_INIT, 1'b1, 32'ha);
			wb(`CPE_ADR_CTRL, 1'b1, md << 4 | 1);
			repeat (3) m.quad(1);
			m.pls(5);
			m.quad(0);
			m.pls(5);
			rc(`CPE_ADR_FIFO, 32'hd, "pos_first");
			rc(`CPE_ADR_FIFO, 32'hc, "pos_second");
		end
		wb(`CPE_ADR_INIT, 1'b1, 32'h0);
		wb(`CPE_ADR_CTRL, 1'b1, 32'h0001_8201);
		repeat (2) m.quad(1);
		m.pls(3);
		rc(`CPE_ADR_FIFO, 32'h8, "quad_capture");
		rc(`CPE_ADR_COUNT, 32'h8, "quad_count");
		wb(`CPE_ADR_CTRL, 1'b1, 32'h0000_0101);
		repeat (2) m.quad(1);
		m.quad(0);
		rc(`CPE_ADR_COUNT, 32'h2, "double_count");
		m.hold = 3;
		wb(`CPE_ADR_CTRL, 1'b1, 32'h0000_0301);
		repeat (3) m.pls(0);
		m.pls(1);
		rc(`CPE_ADR_COUNT, 32'h2, "two_pulse");
		// Output stage plus sixteen queued words fill it; one more drops
		repeat (17) m.pls(5);
		rc(`CPE_ADR_STATUS, 32'h1021, "fifo_full");
		m.pls(5);
		rc(`CPE_ADR_STATUS, 32'h1029, "fifo_overflow");
		wb(`CPE_ADR_STATUS, 1'b1, 32'h8);
		rdy <= 1'b1;
		repeat (20) @(posedge clk_i);
		rdy <= 1'b0;
		chk("drain_count", 32'd17, dq.size());
		chk("drain_last", 32'h2, dq[16]);
		dq.delete();
		rc(`CPE_ADR_STATUS, 32'h11, "drained");
		m.hold = 6;
		wb(`CPE_ADR_CTRL, 1'b1, 32'h0000_0021);
		m.pls(3);
		m.pls(4);
		sep(5);
		sep(2);
		rc(`CPE_ADR_FIFO, 32'h5, "sep_single");
		rc(`CPE_ADR_FIFO, 32'h0, "sep_empty");
		rdy <= 1'b1;
		wb(`CPE_ADR_CTRL, 1'b1, 32'h0000_6031);
		sep(3);
		m.pls(3);
		sep(2);
		repeat (8) @(posedge clk_i);
		chk("dma_count", 32'h2, dq.size());
		chk("dma_first", 32'h3, dq[0]);
		chk("dma_second", 32'h2, dq[1]);
		for (int md = 4; md < 6; md++) begin
			wb(`CPE_ADR_CTRL, 1'b1, md << 4 | 1);
			m.pls(5);
			ovr(1'b1);
			wb(`CPE_ADR_STATUS, 1'b1, 32'h4);
			sep(4);
			m.pls(5);
			ovr(1'b0);
			chk("smp_first", 32'h4, dq[$]);
			m.pls(3);
			sep(2);
			m.pls(5);
			chk("smp_second", 32'h2, dq[$]);
		end
		wb(`CPE_ADR_DELAY, 1'b1, 32'h2);
		wb(`CPE_ADR_WIDTH, 1'b1, 32'h3);
		wb(`CPE_ADR_CTRL, 1'b1, 32'h0000_0061);
		for (int i = 1; i < 7; i++) begin
			m.pls(2);
			chk("pulse", i >= 2 && i < 5, pulse);
		end
		wb(`CPE_ADR_DELAY, 1'b1, 32'h1);
		wb(`CPE_ADR_WIDTH, 1'b1, 32'h2);
		wb(`CPE_ADR_CTRL, 1'b1, 32'h0000_1071);
		m.pls(2);
		chk("untriggered", 32'h0, pulse);
		m.pls(3);
		for (int i = 1; i < 6; i++) begin
			if (i == 2)
				m.pls(3);
			m.pls(2);
			// Falling source edge lands late; let the pulse settle
			repeat (2) @(posedge clk_i);
			chk("triggered", i < 3, pulse);
		end
		wb(`CPE_ADR_CTRL, 1'b1, 32'h0000_0002);
		rc(`CPE_ADR_STATUS, 32'h10, "disarmed");
		end_of_test();
	end
endmodule
bind cpe_counter cpe_counter_props u_props (.clk_i(clk_i),
	.rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .source_i(source_i), .gate_i(gate_i),
	.sample_clk_i(sample_clk_i), .pulse_o(pulse_o),
	.dma_valid_o(dma_valid_o), .dma_data_o(dma_data_o),
	.dma_ready_i(dma_ready_i));
